// ==== hdl/afl_axis_inputs.v ====
// The APB register port and the register offsets were decided locally.
`include "afl_consts.vh"
module afl_axis_inputs #(
   parameter [15:0] SW_FILT_CYC = `AFL_SW_FILT_CYC
) (
   input  wire        MCLK,
   input  wire        RST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   input  wire [3:0]  FWD_LIM,
   input  wire [3:0]  REV_LIM,
   input  wire [3:0]  HOME_SW,
   input  wire [3:0]  DRV_FAULT,
   input  wire [3:0]  DRV_DONE,
   input  wire [3:0]  ENC_A,
   input  wire [3:0]  ENC_B,
   input  wire [3:0]  ENC_IDX,
   output reg  [3:0]  AXIS_HALT,
   output reg  [3:0]  FWD_BLOCK,
   output reg  [3:0]  REV_BLOCK,
   output reg  [3:0]  STEP_BLOCK,
   output reg  [3:0]  MOVE_DONE,
   output reg  [3:0]  IDX_FOUND
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   // ----------------------------------------------------------------
   // software state
   // ----------------------------------------------------------------
   reg  [`AFL_SW_W-1:0] en_q;
   reg  [`AFL_SW_W-1:0] pol_q;
   reg                  bypass_q;
   reg  [3:0]           enc_filt_q;
   reg  [11:0]          enc_pol_q;
   reg  [7:0]           ix_pat_q;
   reg  [3:0]           ix_arm_q;
   reg  [3:0]           ix_cap_q;
   reg  [31:0]          cnt_q [0:3];
   reg  [31:0]          cap_q [0:3];

   wire                 acc_start;
   wire                 wr_go;
   reg  [31:0]          rd_d;
   reg                  err_d;
   wire [3:0]           ix_hit;

   assign acc_start = PSEL & PENABLE & ~PREADY;
   assign wr_go     = PSEL & PENABLE & PREADY & PWRITE;

   // ----------------------------------------------------------------
   // write decode, one strobe per writable register
   // ----------------------------------------------------------------
   wire                 wr_en;
   wire                 wr_pol;
   wire                 wr_filt;
   wire                 wr_encpol;
   wire                 wr_idx;

   assign wr_en     = wr_go & hit(PADDR, `AFL_REG_EN);
   assign wr_pol    = wr_go & hit(PADDR, `AFL_REG_POL);
   assign wr_filt   = wr_go & hit(PADDR, `AFL_REG_FILT);
   assign wr_encpol = wr_go & hit(PADDR, `AFL_REG_ENCPOL);
   assign wr_idx    = wr_go & hit(PADDR, `AFL_REG_IDX);

   // ----------------------------------------------------------------
   // switch conditioning
   // ----------------------------------------------------------------
   wire [`AFL_SW_W-1:0] sw_raw;
   wire [`AFL_SW_W-1:0] sw_pol;
   reg  [`AFL_SW_W-1:0] sw_flt_q;
   wire [`AFL_SW_W-1:0] sw_act;
   wire [`AFL_SW_W-1:0] sw_live;
   reg  [`AFL_SW_W-1:0] sw_live_q;

   assign sw_raw = {DRV_DONE, DRV_FAULT, HOME_SW, REV_LIM, FWD_LIM};
   assign sw_pol = sw_raw ^ pol_q;

   genvar gi;
   generate
      for (gi = 0; gi < `AFL_SW_W; gi = gi + 1) begin : g_sw
         reg [15:0] db_q;
         // a 16-bit counter caps the window near 1.3 ms at 50 MHz
         // debounce: the level must hold for the full window to pass
         always @(posedge MCLK) begin
            if (RST) begin
               db_q           <= 16'h0000;
               sw_flt_q[gi]   <= 1'b0;
            end else if (sw_pol[gi] == sw_flt_q[gi]) begin
               db_q           <= 16'h0000;
            end else if (db_q == SW_FILT_CYC - 16'h0001) begin
               db_q           <= 16'h0000;
               sw_flt_q[gi]   <= sw_pol[gi];
            end else begin
               db_q           <= db_q + 16'h0001;
            end
         end
      end
   endgenerate

   assign sw_act  = bypass_q ? sw_pol : sw_flt_q;
   // disabled inputs drop out here but stay in the state register
   assign sw_live = sw_act & en_q;

   // ----------------------------------------------------------------
   // halt and block outputs
   // ----------------------------------------------------------------
   wire [3:0]           sw_rise;

   // halt is edge based, so a held limit does not halt forever
   assign sw_rise = (sw_live[3:0] & ~sw_live_q[3:0]) |
                    (sw_live[7:4] & ~sw_live_q[7:4]) |
                    (sw_live[11:8] & ~sw_live_q[11:8]);

   always @(posedge MCLK) begin
      if (RST) begin
         sw_live_q  <= {`AFL_SW_W{1'b0}};
         AXIS_HALT  <= 4'h0;
         FWD_BLOCK  <= 4'h0;
         REV_BLOCK  <= 4'h0;
         STEP_BLOCK <= 4'h0;
         MOVE_DONE  <= 4'h0;
      end else begin
         sw_live_q  <= sw_live;
         // one pulse per activation; a pulse shorter than the filter window halts only with bypass_q set
         AXIS_HALT  <= sw_rise;
         // level only: a released limit no longer blocks
         FWD_BLOCK  <= sw_live[`AFL_F_FWD+3:`AFL_F_FWD];
         REV_BLOCK  <= sw_live[`AFL_F_REV+3:`AFL_F_REV];
         STEP_BLOCK <= sw_live[`AFL_F_FAULT+3:`AFL_F_FAULT];
         MOVE_DONE  <= sw_live[`AFL_F_DONE+3:`AFL_F_DONE];
      end
   end

   // ----------------------------------------------------------------
   // encoder channels
   // ----------------------------------------------------------------
   wire [11:0] enc_raw;
   wire [11:0] enc_pol;
   reg  [11:0] enc_flt_q;

   assign enc_raw = {ENC_IDX, ENC_B, ENC_A};
   assign enc_pol = enc_raw ^ enc_pol_q;

   generate
      for (gi = 0; gi < 12; gi = gi + 1) begin : g_ef
         reg [3:0] ef_q;
         // long settings lower the usable count rate, keep them short
         always @(posedge MCLK) begin
            if (RST) begin
               ef_q          <= 4'h0;
               enc_flt_q[gi] <= 1'b0;
            end else if (enc_pol[gi] == enc_flt_q[gi]) begin
               ef_q          <= 4'h0;
            end else if (ef_q == enc_filt_q) begin
               ef_q          <= 4'h0;
               enc_flt_q[gi] <= enc_pol[gi];
            end else begin
               ef_q          <= ef_q + 4'h1;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // quadrature decode and index qualify
   // ----------------------------------------------------------------
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_enc
         wire a;
         wire b;
         wire z;
         reg  a_q;
         reg  b_q;
         reg  z_q;
         wire step;
         wire up;

         assign a = enc_flt_q[`AFL_EP_A + gi];
         assign b = enc_flt_q[`AFL_EP_B + gi];
         assign z = enc_flt_q[`AFL_EP_I + gi];
         // both phases moving at once is illegal and not counted
         assign step = a ^ a_q ^ b ^ b_q;
         assign up   = a ^ b_q;
         assign ix_hit[gi] = z & ~z_q & ix_arm_q[gi] &
                             ({b, a} == ix_pat_q[2*gi+1:2*gi]);
         always @(posedge MCLK) begin
            if (RST) begin
               a_q        <= 1'b0;
               b_q        <= 1'b0;
               z_q        <= 1'b0;
               cnt_q[gi]  <= 32'h00000000;
               cap_q[gi]  <= 32'h00000000;
            end else begin
               a_q <= a;
               b_q <= b;
               z_q <= z;
               // one decision per clock keeps pace with 4 MHz edges
               if (step) begin
                  // natural 32-bit overflow gives the wrap
                  if (up) begin
                     cnt_q[gi] <= cnt_q[gi] + 32'h00000001;
                  end else begin
                     cnt_q[gi] <= cnt_q[gi] - 32'h00000001;
                  end
               end
               if (ix_hit[gi]) begin
                  cap_q[gi] <= cnt_q[gi];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // index found flag
   // ----------------------------------------------------------------
   always @(posedge MCLK) begin
      if (RST) begin
         IDX_FOUND <= 4'h0;
      end else begin
         IDX_FOUND <= ix_hit;
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always @(posedge MCLK) begin
      if (RST) begin
         en_q       <= `AFL_EN_RST;
         pol_q      <= `AFL_POL_RST;
         bypass_q   <= 1'b0;
         enc_filt_q <= `AFL_FILT_RST;
         enc_pol_q  <= `AFL_ENCPOL_RST;
         ix_pat_q   <= `AFL_IXPAT_RST;
         ix_arm_q   <= 4'h0;
         ix_cap_q   <= 4'h0;
      end else begin
         if (wr_en) begin
            en_q <= PWDATA[`AFL_SW_W-1:0];
         end
         if (wr_pol) begin
            pol_q <= PWDATA[`AFL_SW_W-1:0];
         end
         if (wr_filt) begin
            bypass_q   <= PWDATA[`AFL_FILT_BYPASS];
            enc_filt_q <= PWDATA[`AFL_FILT_ENC_HI:`AFL_FILT_ENC_LO];
         end
         if (wr_encpol) begin
            enc_pol_q <= PWDATA[11:0];
         end
         if (wr_idx) begin
            ix_pat_q <= PWDATA[7:0];
         end
         // a capture disarms; a fresh arm written in that cycle wins
         ix_arm_q <= (ix_arm_q & ~ix_hit) |
                     (wr_idx ? PWDATA[`AFL_IX_ARM+3:`AFL_IX_ARM] :
                      4'h0);
         // write one clears; a new capture in that cycle wins
         ix_cap_q <= (wr_idx ?
                      (ix_cap_q & ~PWDATA[`AFL_IX_CAP+3:`AFL_IX_CAP]) :
                      ix_cap_q) | ix_hit;
      end
   end

   // ----------------------------------------------------------------
   // read-only guard
   // ----------------------------------------------------------------
   wire                 ro_hit;

   // counter, capture and state words are read-only
   assign ro_hit = (PADDR[7:4] == `AFL_REG_CNT_BASE) ||
                   (PADDR[7:4] == `AFL_REG_CAP_BASE) ||
                   hit(PADDR, `AFL_REG_STATE);

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   always @* begin
      rd_d  = 32'h00000000;
      err_d = 1'b0;
      if (hit(PADDR, `AFL_REG_EN)) begin
         rd_d = {12'h000, en_q};
      end else if (hit(PADDR, `AFL_REG_POL)) begin
         rd_d = {12'h000, pol_q};
      end else if (hit(PADDR, `AFL_REG_STATE)) begin
         rd_d = {12'h000, sw_act};
      end else if (hit(PADDR, `AFL_REG_FILT)) begin
         rd_d = {20'h00000, enc_filt_q, 7'h00, bypass_q};
      end else if (hit(PADDR, `AFL_REG_ENCPOL)) begin
         rd_d = {20'h00000, enc_pol_q};
      end else if (hit(PADDR, `AFL_REG_IDX)) begin
         rd_d = {16'h0000, ix_cap_q, ix_arm_q, ix_pat_q};
      end else if (PADDR[7:4] == `AFL_REG_CNT_BASE &&
                   PADDR[1:0] == 2'b00) begin
         rd_d = cnt_q[PADDR[3:2]];
      end else if (PADDR[7:4] == `AFL_REG_CAP_BASE &&
                   PADDR[1:0] == 2'b00) begin
         rd_d = cap_q[PADDR[3:2]];
      end else begin
         err_d = 1'b1;
      end
      if (PWRITE && ro_hit) begin
         err_d = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // apb answer, one wait state so every output is registered
   // ----------------------------------------------------------------
   always @(posedge MCLK) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h00000000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= acc_start;
         if (acc_start) begin
            if (PWRITE) begin
               PRDATA  <= 32'h00000000;
            end else begin
               PRDATA  <= rd_d;
            end
            PSLVERR <= err_d;
         end else begin
            PSLVERR <= 1'b0;
         end
      end
   end

endmodule

// ==== hdl/afl_consts.vh ====
`ifndef AFL_CONSTS_VH
`define AFL_CONSTS_VH
// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define AFL_CLK_KHZ        50000
`define AFL_SW_FILT_US     1000
`define AFL_SW_FILT_CYC    ((`AFL_SW_FILT_US * `AFL_CLK_KHZ) / 1000)
// ----------------------------------------------------------------
// register byte offsets, and the PADDR[7:4] bases of the counter and capture words
// ----------------------------------------------------------------
`define AFL_REG_EN         8'h00
`define AFL_REG_POL        8'h04
`define AFL_REG_STATE      8'h08
`define AFL_REG_FILT       8'h0c
`define AFL_REG_ENCPOL     8'h10
`define AFL_REG_IDX        8'h14
`define AFL_REG_CNT_BASE   4'h2
`define AFL_REG_CAP_BASE   4'h3
// ----------------------------------------------------------------
// switch field layout (bit groups of four, one bit per axis)
// ----------------------------------------------------------------
`define AFL_SW_W           20
`define AFL_F_FWD          0
`define AFL_F_REV          4
`define AFL_F_HOME         8
`define AFL_F_FAULT        12
`define AFL_F_DONE         16
// ----------------------------------------------------------------
// filter register fields
// ----------------------------------------------------------------
`define AFL_FILT_BYPASS    0
`define AFL_FILT_ENC_LO    8
`define AFL_FILT_ENC_HI    11
// ----------------------------------------------------------------
// encoder polarity and index register fields
// ----------------------------------------------------------------
`define AFL_EP_A           0
`define AFL_EP_B           4
`define AFL_EP_I           8
`define AFL_IX_ARM         8
`define AFL_IX_CAP         12
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AFL_EN_RST         20'h00000
`define AFL_POL_RST        20'h00000
`define AFL_FILT_RST       4'h0
`define AFL_ENCPOL_RST     12'h000
`define AFL_IXPAT_RST      8'h00
`endif

// ==== tb/afl_checker.sv ====
`include "afl_consts.vh"
module afl_checker (
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [3:0]  AXIS_HALT,
   input wire logic [3:0]  FWD_BLOCK,
   input wire logic [3:0]  REV_BLOCK,
   input wire logic [3:0]  STEP_BLOCK,
   input wire logic [3:0]  MOVE_DONE,
   input wire logic [3:0]  IDX_FOUND
);
   timeunit 1ns;
   timeprecision 1ps;
   // -------------------------------------------------
   // shadow of the enable register
   // -------------------------------------------------
   logic [19:0] en_q, en1_q, en2_q, off;
   // outputs lag the enable by one stage; the mask allows up to two
   assign off = ~(en_q | en1_q | en2_q);
   always_ff @(posedge MCLK) begin
      if (RST) begin
         en_q  <= 20'h00000;
         en1_q <= 20'h00000;
         en2_q <= 20'h00000;
      end else begin
         if (PSEL && PENABLE && PREADY && PWRITE &&
             PADDR == `AFL_REG_EN) begin
            en_q <= PWDATA[19:0];
         end
         en1_q <= en_q;
         en2_q <= en1_q;
      end
   end
   // -------------------------------------------------
   // assertions
   // -------------------------------------------------
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   ready_answer_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("access not answered");
   ready_once_a: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   err_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   travel_gate_a: assert property (
      ({REV_BLOCK, FWD_BLOCK} & off[7:0]) == 8'h00)
      else $error("block from disabled input");
   step_gate_a: assert property ((STEP_BLOCK & off[15:12]) == 4'h0)
      else $error("step block from disabled fault");
   done_gate_a: assert property ((MOVE_DONE & off[19:16]) == 4'h0)
      else $error("done from disabled input");
   halt_gate_a: assert property (
      (AXIS_HALT & off[3:0] & off[7:4] & off[11:8]) == 4'h0)
      else $error("halt from disabled input");
   halt_pulse_a: assert property ((AXIS_HALT & $past(AXIS_HALT)) == 4'h0)
      else $error("halt longer than a pulse");
   block_halt_a: assert property ((((FWD_BLOCK & ~$past(FWD_BLOCK))
      | (REV_BLOCK & ~$past(REV_BLOCK))) & ~AXIS_HALT) == 4'h0)
      else $error("block rose without halt");
   idx_pulse_a: assert property (|IDX_FOUND |=>
      (IDX_FOUND & $past(IDX_FOUND)) == 4'h0)
      else $error("index flag too long");
   cover property (|AXIS_HALT);
   cover property (|IDX_FOUND);
   cover property (PREADY && PSLVERR);
endmodule
bind afl_axis_inputs afl_checker i_chk (.MCLK, .RST, .PSEL, .PENABLE, .PWRITE,
   .PADDR, .PWDATA, .PREADY, .PSLVERR, .AXIS_HALT, .FWD_BLOCK, .REV_BLOCK,
   .STEP_BLOCK, .MOVE_DONE, .IDX_FOUND);

// ==== tb/afl_field_model.sv ====
module afl_field_model (
   input  wire logic  clk,
   output logic [3:0] fwd, rev, home, fault, done, enc_a, enc_b, idx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph [4] = '{default: 2'b00};
   initial begin
      {done, fault, home, rev, fwd} = 20'h00000;
      idx = 4'h0;
   end
   // -------------------------------------------------
   // both phases always present, a leads b upward
   // -------------------------------------------------
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         enc_a[k] = ph[k] == 2'd1 || ph[k] == 2'd2;
         enc_b[k] = ph[k][1];
      end
   end
   task automatic set_sw(input logic [19:0] v);
      @(posedge clk);
      {done, fault, home, rev, fwd} <= v;
   endtask
   // four cycles per count keeps within the decoder's filter spacing
   task automatic move(input int ax, input int n);
      repeat (n < 0 ? -n : n) begin
         @(posedge clk);
         ph[ax] <= ph[ax] + (n < 0 ? 2'd3 : 2'd1);
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic pulse_idx(input logic [3:0] m);
      @(posedge clk);
      idx <= m;
      repeat (3) @(posedge clk);
      idx <= 4'h0;
   endtask
endmodule

// ==== tb/tb.sv ====
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
   logic        PWRITE = 1'b0, PREADY, PSLVERR, rerr;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
   logic [3:0]  FWD_LIM, REV_LIM, HOME_SW, DRV_FAULT, DRV_DONE;
   logic [3:0]  ENC_A, ENC_B, ENC_IDX, AXIS_HALT, FWD_BLOCK, REV_BLOCK;
   logic [3:0]  STEP_BLOCK, MOVE_DONE, IDX_FOUND;
   int          mismatches = 0, comparisons = 0, halts = 0, idxs = 0;
   always #10 MCLK = ~MCLK;
   // short debounce so a filtered input settles in a few cycles
   afl_axis_inputs #(.SW_FILT_CYC(16'h0004)) i_dut (.MCLK, .RST, .PSEL,
      .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
      .FWD_LIM, .REV_LIM, .HOME_SW, .DRV_FAULT, .DRV_DONE, .ENC_A, .ENC_B,
      .ENC_IDX, .AXIS_HALT, .FWD_BLOCK, .REV_BLOCK, .STEP_BLOCK, .MOVE_DONE,
      .IDX_FOUND);
   afl_field_model i_fm (.clk(MCLK), .fwd(FWD_LIM), .rev(REV_LIM),
      .home(HOME_SW), .fault(DRV_FAULT), .done(DRV_DONE), .enc_a(ENC_A),
      .enc_b(ENC_B), .idx(ENC_IDX));
   always @(posedge MCLK) begin
      if (AXIS_HALT[0] === 1'b1) halts++;
      if (|IDX_FOUND === 1'b1) idxs++;
   end
   // -------------------------------------------------
   // bus and compare helpers
   // -------------------------------------------------
   task automatic conclude();
      if (mismatches == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge MCLK);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge MCLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   // -------------------------------------------------
   // scenarios
   // -------------------------------------------------
   initial begin
      cyc(4);
      RST <= 1'b0;
      for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h08, 32'h5);
      chk({31'h0, rerr}, 32'h1);
      i_fm.set_sw(20'h00001);
      cyc(10);
      rd(8'h08, 32'h1);
      chk(32'(FWD_BLOCK) | 32'(halts), 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      cyc(3);
      chk(32'(halts), 32'h1);
      chk({REV_BLOCK, FWD_BLOCK}, 8'h01);
      i_fm.set_sw(20'h0);
      cyc(10);
      chk(32'(FWD_BLOCK), 32'h0);
      i_fm.set_sw(20'h1);
      cyc(1);
      i_fm.set_sw(20'h0);
      cyc(10);
      chk(32'(halts), 32'h1);
      i_fm.set_sw(20'h1);
      cyc(6);
      i_fm.set_sw(20'h0);
      cyc(10);
      chk(32'(halts) + 32'(FWD_BLOCK), 32'h2);
      apb(1'b1, 8'h0c, 32'h1);
      apb(1'b1, 8'h00, 32'h100);
      i_fm.set_sw(20'h00100);
      i_fm.set_sw(20'h0);
      cyc(4);
      chk(32'(halts), 32'h3);
      apb(1'b1, 8'h04, 32'h10);
      apb(1'b1, 8'h00, 32'h10);
      cyc(3);
      chk(32'(halts) + 32'(REV_BLOCK), 32'h5);
      apb(1'b1, 8'h00, 32'hf000);
      i_fm.set_sw(20'h22000);
      cyc(3);
      chk({STEP_BLOCK, MOVE_DONE}, 8'h20);
      rd(8'h08, 32'h22010);
      apb(1'b1, 8'h00, 32'hff000);
      cyc(3);
      chk(32'(MOVE_DONE), 32'h2);
      for (int ax = 0; ax < 4; ax++) i_fm.move(ax, 5 * ax - 7);
      cyc(4);
      for (int ax = 0; ax < 4; ax++)
         rd(8'(32 + 4 * ax), 32'(5 * ax - 7));
      apb(1'b1, 8'h14, 32'h800);
      i_fm.pulse_idx(4'h8);
      cyc(3);
      rd(8'h3c, 32'h8);
      apb(1'b1, 8'h14, 32'h60c);
      i_fm.pulse_idx(4'h6);
      cyc(3);
      rd(8'h34, 32'hfffffffe);
      rd(8'h14, 32'ha40c);
      apb(1'b1, 8'h20, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, 8'h10, 32'h1);
      chk(rdat, 32'h0);
      cyc(3);
      rd(8'h20, 32'hfffffff8);
      apb(1'b1, 8'h0c, 32'h301);
      apb(1'b1, 8'h14, 32'h10c);
      i_fm.pulse_idx(4'h1);
      cyc(6);
      rd(8'h14, 32'ha50c);
      i_fm.set_sw(20'hfffff);
      cyc(3);
      rd(8'h08, 32'hfffef);
      chk({STEP_BLOCK, MOVE_DONE}, 8'hff);
      chk(32'(idxs), 32'h2);
      conclude();
   end
   initial begin
      #100us;
      mismatches++;
      conclude();
   end
endmodule
